/* hdl/tcr_pkg.sv */
/*
  Constants, field positions and codes for the translation control
  register block. Assumes one 50 MHz clock and an AXI4-Lite master.
*/
package tcr_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] TCR_OFF_TRANSLATION_CONTROL = 12'h000;
  localparam logic [11:0] TCR_OFF_BANK_CONFIG         = 12'h004;
  localparam logic [11:0] TCR_OFF_STATUS              = 12'h008;
  localparam logic [31:0] TCR_RST_TRANSLATION_CONTROL = 32'h0000_0000;
  localparam logic [4:0]  TCR_RST_BANK_CONFIG         = 5'h00;
  // ---------------------------------------------------------------
  // translation control fields
  // ---------------------------------------------------------------
  localparam int TCR_B_EXT_DESC     = 31;
  localparam int TCR_B_UP_NS        = 30;
  localparam int TCR_B_UP_SH        = 28;
  localparam int TCR_B_UP_OUTER     = 26;
  localparam int TCR_B_UP_INNER     = 24;
  localparam int TCR_B_UP_DIS       = 23;
  localparam int TCR_B_ASID_SEL     = 22;
  localparam int TCR_B_UP_OFF       = 16;
  localparam int TCR_B_LO_GRAN      = 14;
  localparam int TCR_B_LO_NS        = 14;
  localparam int TCR_B_LO_SH        = 12;
  localparam int TCR_B_LO_OUTER     = 10;
  localparam int TCR_B_LO_INNER     = 8;
  localparam int TCR_B_LO_DIS       = 7;
  localparam int TCR_B_UP_DIS_SHORT = 5;
  localparam int TCR_B_LO_DIS_SHORT = 4;
  localparam int TCR_B_UP_GRAN      = 30;
  localparam int TCR_B_LO_OFF       = 0;
  // ---------------------------------------------------------------
  // bank configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_B_64BIT   = 0;
  localparam int CFG_B_STAGE2  = 1;
  localparam int CFG_B_HYP     = 2;
  localparam int CFG_B_MONITOR = 3;
  localparam int CFG_B_SECURE  = 4;
  // ---------------------------------------------------------------
  // attribute and granule codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TCR_SH_NON = 2'h0, TCR_SH_UNPRED = 2'h1,
    TCR_SH_OUTER = 2'h2, TCR_SH_INNER = 2'h3
  } tcr_share_t;
  typedef enum logic [1:0] {
    TCR_C_NONE = 2'h0, TCR_C_WB_WA = 2'h1,
    TCR_C_WT = 2'h2, TCR_C_WB_NOWA = 2'h3
  } tcr_cache_t;
  typedef enum logic [1:0] {
    TCR_G_4K = 2'h0, TCR_G_16K = 2'h1, TCR_G_64K = 2'h2
  } tcr_gran_t;
  localparam logic [6:0] TCR_VA32_LOG2 = 7'h20;
  localparam logic [6:0] TCR_BANK_64BIT_ADDRESS_LOG2 = 7'h40;
  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;
endpackage

/* hdl/tcr_translation_control.sv */
/*
  Translation control register of one context bank with its AXI4-Lite
  slave and the TLB miss decision path.
  Assumes a single clock, synchronous inputs and a miss requester that
  samples the result outputs on the MISS_DONE pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tcr_translation_control
  import tcr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic        MISS_REQ,
  input  wire logic        MISS_UPPER,
  output var  logic        MISS_DONE,
  output var  logic        MISS_WALK,
  output var  logic        MISS_FAULT,
  output var  logic        MISS_NS,
  output var  logic [1:0]  MISS_SH,
  output var  logic [1:0]  MISS_OUTER,
  output var  logic [1:0]  MISS_INNER,
  output var  logic [1:0]  MISS_GRANULE,
  output var  logic [6:0]  MISS_REGION_LOG2,
  output var  logic        ASID_FROM_UPPER,
  output var  logic        LONG_DESC
);

  // ---------------------------------------------------------------
  // granule decoding
  // ---------------------------------------------------------------
  // reserved codes act as 4KB; readback keeps the written code
  function automatic tcr_gran_t gran_decode(input logic [1:0] code,
                                            input logic       upper);
    tcr_gran_t g;
    g = TCR_G_4K;
    if (upper) begin
      unique case (code)
        2'h1:    g = TCR_G_16K;
        2'h3:    g = TCR_G_64K;
        default: g = TCR_G_4K;
      endcase
    end else begin
      unique case (code)
        2'h1:    g = TCR_G_64K;
        2'h2:    g = TCR_G_16K;
        default: g = TCR_G_4K;
      endcase
    end
    return g;
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] translation_control_r;
  logic [31:0] translation_control_nxt;
  logic [4:0]  bank_config_r;
  logic [4:0]  bank_config_nxt;
  logic        aw_hold_r;
  logic        aw_hold_nxt;
  logic [11:0] aw_addr_r;
  logic        w_hold_r;
  logic        w_hold_nxt;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        miss_done_r;
  logic        miss_walk_r;
  logic        miss_fault_r;
  logic        miss_ns_r;
  logic [1:0]  miss_sh_r;
  logic [1:0]  miss_outer_r;
  logic [1:0]  miss_inner_r;
  logic [1:0]  miss_gran_r;
  logic [6:0]  miss_log2_r;
  logic        asid_upper_r;
  logic        long_desc_r;
  logic        last_fault_r;
  logic        last_fault_nxt;

  // ---------------------------------------------------------------
  // field views
  // ---------------------------------------------------------------
  wire logic [31:0] tc = translation_control_r;
  wire logic        bank_64bit_address = bank_config_r[CFG_B_64BIT];
  wire logic        stage2_context     = bank_config_r[CFG_B_STAGE2];
  wire logic        hypervisor_context = bank_config_r[CFG_B_HYP];
  wire logic        monitor_context    = bank_config_r[CFG_B_MONITOR];
  wire logic        secure_bank        = bank_config_r[CFG_B_SECURE];

  // effective long-descriptor select
  wire logic extended_descriptor_select = tc[TCR_B_EXT_DESC];
  wire logic eff_long = extended_descriptor_select | stage2_context
                      | hypervisor_context | bank_64bit_address;

  // long-layout walk disables are meaningless here and are ignored
  wire logic dis_ignored = ~eff_long | hypervisor_context;

  wire logic upper_walk_disable = tc[TCR_B_UP_DIS];
  wire logic lower_walk_disable = tc[TCR_B_LO_DIS];
  wire logic upper_walk_disable_short = tc[TCR_B_UP_DIS_SHORT];
  wire logic lower_walk_disable_short = tc[TCR_B_LO_DIS_SHORT];

  wire logic up_dis_eff = eff_long
    ? (~dis_ignored & upper_walk_disable)
    : upper_walk_disable_short;
  wire logic lo_dis_eff = eff_long
    ? (~dis_ignored & lower_walk_disable)
    : lower_walk_disable_short;

  // non-secure banks always walk non-secure
  wire logic upper_walk_nonsecure = tc[TCR_B_UP_NS];
  wire logic lower_walk_nonsecure = tc[TCR_B_LO_NS];
  wire logic up_ns_eff = secure_bank ? upper_walk_nonsecure : 1'b1;
  wire logic lo_ns_eff = secure_bank ? lower_walk_nonsecure : 1'b1;

  wire logic [1:0] upper_walk_shareability = tc[TCR_B_UP_SH +: 2];
  wire logic [1:0] lower_walk_shareability = tc[TCR_B_LO_SH +: 2];
  wire logic [1:0] upper_walk_outer_cache  = tc[TCR_B_UP_OUTER +: 2];
  wire logic [1:0] lower_walk_outer_cache  = tc[TCR_B_LO_OUTER +: 2];
  wire logic [1:0] upper_walk_inner_cache  = tc[TCR_B_UP_INNER +: 2];
  wire logic [1:0] lower_walk_inner_cache  = tc[TCR_B_LO_INNER +: 2];

  wire logic asid_source_select = tc[TCR_B_ASID_SEL];

  // region size offsets per layout
  wire logic [5:0] upper_region_size_offset = bank_64bit_address
    ? tc[TCR_B_UP_OFF +: 6]
    : {3'h0, tc[TCR_B_UP_OFF +: 3]};
  wire logic [5:0] lower_region_size_offset = bank_64bit_address
    ? tc[TCR_B_LO_OFF +: 6]
    : {3'h0, tc[TCR_B_LO_OFF +: 3]};
  wire logic [6:0] va_log2 = bank_64bit_address ? TCR_BANK_64BIT_ADDRESS_LOG2
                                                 : TCR_VA32_LOG2;
  wire logic [6:0] up_log2 = va_log2 - {1'b0, upper_region_size_offset};
  wire logic [6:0] lo_log2 = va_log2 - {1'b0, lower_region_size_offset};

  // granules exist only in the 64-bit layout
  wire logic upper_gran_applies = ~stage2_context & ~hypervisor_context
                                & ~monitor_context;
  wire logic [1:0] upper_granule = tc[TCR_B_UP_GRAN +: 2];
  wire logic [1:0] lower_granule = tc[TCR_B_LO_GRAN +: 2];
  wire tcr_gran_t lo_gran = gran_decode(lower_granule, 1'b0);
  wire tcr_gran_t up_gran = upper_gran_applies
    ? gran_decode(upper_granule, 1'b1) : lo_gran;
  wire tcr_gran_t up_gran_eff = bank_64bit_address ? up_gran : TCR_G_4K;
  wire tcr_gran_t lo_gran_eff = bank_64bit_address ? lo_gran : TCR_G_4K;

  // ---------------------------------------------------------------
  // miss decision, sampled from the register as it stands
  // ---------------------------------------------------------------
  wire logic miss_dis = MISS_UPPER ? up_dis_eff : lo_dis_eff;
  assign last_fault_nxt = MISS_REQ ? miss_dis : last_fault_r;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      miss_done_r  <= 1'b0;
      miss_walk_r  <= 1'b0;
      miss_fault_r <= 1'b0;
    end else begin
      miss_done_r  <= MISS_REQ;
      miss_walk_r  <= MISS_REQ & ~miss_dis;
      miss_fault_r <= MISS_REQ & miss_dis;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      miss_ns_r    <= 1'b0;
      miss_sh_r    <= 2'h0;
      miss_outer_r <= 2'h0;
      miss_inner_r <= 2'h0;
      miss_gran_r  <= 2'h0;
      miss_log2_r  <= 7'h00;
    end else if (MISS_REQ) begin
      miss_ns_r    <= MISS_UPPER ? up_ns_eff : lo_ns_eff;
      miss_sh_r    <= MISS_UPPER ? upper_walk_shareability
                                 : lower_walk_shareability;
      miss_outer_r <= MISS_UPPER ? upper_walk_outer_cache
                                 : lower_walk_outer_cache;
      miss_inner_r <= MISS_UPPER ? upper_walk_inner_cache
                                 : lower_walk_inner_cache;
      miss_gran_r  <= MISS_UPPER ? up_gran_eff : lo_gran_eff;
      miss_log2_r  <= MISS_UPPER ? up_log2 : lo_log2;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      asid_upper_r <= 1'b0;
      long_desc_r  <= 1'b0;
      last_fault_r <= 1'b0;
    end else begin
      asid_upper_r <= asid_source_select;
      long_desc_r  <= eff_long;
      last_fault_r <= last_fault_nxt;
    end
  end

  // ---------------------------------------------------------------
  // bus write channel
  // ---------------------------------------------------------------
  wire logic aw_take  = AWVALID & awready_r;
  wire logic w_take   = WVALID & wready_r;
  wire logic do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  wire logic wr_tc    = do_write & (aw_addr_r == TCR_OFF_TRANSLATION_CONTROL);
  wire logic wr_cfg   = do_write & (aw_addr_r == TCR_OFF_BANK_CONFIG);
  wire logic wr_ok    = wr_tc | wr_cfg | (aw_addr_r == TCR_OFF_STATUS);

  assign aw_hold_nxt = aw_take | (aw_hold_r & ~do_write);
  assign w_hold_nxt  = w_take | (w_hold_r & ~do_write);
  assign bvalid_nxt  = do_write | (bvalid_r & ~BREADY);

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign translation_control_nxt[lane*8 +: 8] =
        (wr_tc & w_strb_r[lane]) ? w_data_r[lane*8 +: 8]
                                 : translation_control_r[lane*8 +: 8];
    end
  endgenerate
  assign bank_config_nxt = (wr_cfg & w_strb_r[0]) ? w_data_r[4:0]
                                                  : bank_config_r;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      translation_control_r <= TCR_RST_TRANSLATION_CONTROL;
      bank_config_r         <= TCR_RST_BANK_CONFIG;
    end else begin
      translation_control_r <= translation_control_nxt;
      bank_config_r         <= bank_config_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= AXI_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_r <= {AWADDR[11:2], 2'h0};
      end
      if (w_take) begin
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus read channel
  // ---------------------------------------------------------------
  wire logic [11:0] rd_addr = {ARADDR[11:2], 2'h0};
  wire logic        ar_take = ARVALID & arready_r;
  // long-layout disables read as zero only in hypervisor context; other ignored cases read back as written
  wire logic [31:0] tc_read = tc & ~({31'h0, dis_ignored & eff_long}
                              << TCR_B_LO_DIS)
                              & ~({31'h0, dis_ignored & eff_long}
                              << TCR_B_UP_DIS);
  wire logic [31:0] status_word = {24'h0, last_fault_r, lo_ns_eff,
                                   up_ns_eff, lo_dis_eff, up_dis_eff,
                                   asid_source_select, bank_64bit_address,
                                   eff_long};
  wire logic        rd_hit_tc  = (rd_addr == TCR_OFF_TRANSLATION_CONTROL);
  wire logic        rd_hit_cfg = (rd_addr == TCR_OFF_BANK_CONFIG);
  wire logic        rd_hit_st  = (rd_addr == TCR_OFF_STATUS);
  wire logic [31:0] rd_word = rd_hit_tc  ? tc_read
                            : rd_hit_cfg ? {27'h0, bank_config_r}
                            : rd_hit_st  ? status_word
                            : 32'h0000_0000;
  assign rvalid_nxt = ar_take | (rvalid_r & ~RREADY);

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= AXI_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= (rd_hit_tc | rd_hit_cfg | rd_hit_st) ? AXI_OKAY
                                                        : AXI_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AWREADY          = awready_r;
  assign WREADY           = wready_r;
  assign BVALID           = bvalid_r;
  assign BRESP            = bresp_r;
  assign ARREADY          = arready_r;
  assign RVALID           = rvalid_r;
  assign RDATA            = rdata_r;
  assign RRESP            = rresp_r;
  assign MISS_DONE        = miss_done_r;
  assign MISS_WALK        = miss_walk_r;
  assign MISS_FAULT       = miss_fault_r;
  assign MISS_NS          = miss_ns_r;
  assign MISS_SH          = miss_sh_r;
  assign MISS_OUTER       = miss_outer_r;
  assign MISS_INNER       = miss_inner_r;
  assign MISS_GRANULE     = miss_gran_r;
  assign MISS_REGION_LOG2 = miss_log2_r;
  assign ASID_FROM_UPPER  = asid_upper_r;
  assign LONG_DESC        = long_desc_r;

endmodule
`default_nettype wire

/* tb/tcr_checker.sv */
/*
  Concurrent checks on the ports of the translation control block.
  Assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tcr_checker
  import tcr_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        MISS_REQ,
  input wire logic        MISS_DONE,
  input wire logic        MISS_WALK,
  input wire logic        MISS_FAULT,
  input wire logic        MISS_NS,
  input wire logic [1:0]  MISS_SH,
  input wire logic [1:0]  MISS_OUTER,
  input wire logic [1:0]  MISS_INNER,
  input wire logic [1:0]  MISS_GRANULE,
  input wire logic [6:0]  MISS_REGION_LOG2
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ---------------------------------------------------------------
  // miss path
  // ---------------------------------------------------------------
  AST_MISS_ANSWER: assert property (MISS_REQ |=> MISS_DONE)
    else $error("miss request got no answer");
  AST_DONE_CAUSE: assert property (MISS_DONE |->
    $past(MISS_REQ))
    else $error("miss answer without request");
  AST_ONE_OUTCOME: assert property (MISS_DONE |->
    MISS_WALK ^ MISS_FAULT)
    else $error("miss answer not exactly walk or fault");
  AST_QUIET: assert property (!MISS_DONE |->
    !(MISS_WALK || MISS_FAULT))
    else $error("walk or fault outside miss answer");
  AST_ATTR_HOLD: assert property (!$past(MISS_REQ) |->
    $stable({MISS_NS, MISS_SH, MISS_OUTER, MISS_INNER, MISS_GRANULE,
             MISS_REGION_LOG2}))
    else $error("walk attributes changed without request");
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  AST_B_BUSY: assert property ($rose(BVALID) |->
    !AWREADY && !WREADY)
    else $error("write channels ready with response pending");
  AST_B_DROP: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response not retired");
  AST_R_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read address taken without data");
  AST_AR_BLOCK: assert property (RVALID |-> !ARREADY)
    else $error("read address ready while data pending");
  cover property (MISS_DONE && MISS_FAULT);
  cover property (MISS_DONE && MISS_WALK);
  cover property (BVALID && BRESP == AXI_SLVERR);
endmodule
`default_nettype wire

/* tb/translation_control_reg_tb.sv */
/*
  Self-checking bench for the translation control block.
  Assumes the block answers misses one edge after the request.
*/
`timescale 1ns/1ps
`default_nettype none
module translation_control_reg_tb
  import tcr_pkg::*;
;
  logic        CLK_SYS = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [11:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, RDATA;
  logic [3:0]  WSTRB = 4'hF;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
  logic        RREADY = 1'b0, MISS_REQ = 1'b0, MISS_UPPER = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, MISS_DONE;
  logic        MISS_WALK, MISS_FAULT, MISS_NS, ASID_FROM_UPPER, LONG_DESC;
  logic [1:0]  BRESP, RRESP, MISS_SH, MISS_OUTER, MISS_INNER, MISS_GRANULE;
  logic [6:0]  MISS_REGION_LOG2;
  int          n_fail = 0;
  int          comparisons = 0;
  always #10 CLK_SYS = ~CLK_SYS;
  tcr_translation_control uut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .MISS_REQ(MISS_REQ), .MISS_UPPER(MISS_UPPER),
    .MISS_DONE(MISS_DONE), .MISS_WALK(MISS_WALK), .MISS_FAULT(MISS_FAULT),
    .MISS_NS(MISS_NS), .MISS_SH(MISS_SH), .MISS_OUTER(MISS_OUTER),
    .MISS_INNER(MISS_INNER), .MISS_GRANULE(MISS_GRANULE),
    .MISS_REGION_LOG2(MISS_REGION_LOG2), .ASID_FROM_UPPER(ASID_FROM_UPPER),
    .LONG_DESC(LONG_DESC));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_up();
    n_fail++;
    $display("BAD handshake expected answer seen timeout");
    stop_test();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    BREADY <= 1'b0;
    if (i == 40) give_up();
    chk("bresp", 32'(er), 32'(BRESP));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    RREADY <= 1'b0;
    if (i == 40) give_up();
    chk("rdata", ed, RDATA);
    chk("rresp", 32'(er), 32'(RRESP));
  endtask
  task automatic set(input logic [4:0] c, input logic [31:0] t);
    wr(TCR_OFF_BANK_CONFIG, 32'(c), AXI_OKAY);
    wr(TCR_OFF_TRANSLATION_CONTROL, t, AXI_OKAY);
  endtask
  task automatic miss(input logic u);
    @(posedge CLK_SYS);
    MISS_REQ <= 1'b1;
    MISS_UPPER <= u;
    @(posedge CLK_SYS);
    MISS_REQ <= 1'b0;
    #1;
    chk("miss done", 32'h1, 32'(MISS_DONE));
  endtask
  task automatic expw(input logic u, input logic w);
    miss(u);
    chk("walk", 32'(w), 32'(MISS_WALK));
    chk("fault", 32'(!w), 32'(MISS_FAULT));
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_regs();
    wr(TCR_OFF_TRANSLATION_CONTROL, 32'hA5C3_3C5A, AXI_OKAY);
    rd(TCR_OFF_TRANSLATION_CONTROL, 32'hA5C3_3C5A, AXI_OKAY);
    wr(TCR_OFF_TRANSLATION_CONTROL, 32'h5A3C_C3A5, AXI_OKAY);
    rd(TCR_OFF_TRANSLATION_CONTROL, 32'h5A3C_C3A5, AXI_OKAY);
    WSTRB <= 4'h3;
    wr(TCR_OFF_TRANSLATION_CONTROL, 32'hFFFF_FFFF, AXI_OKAY);
    WSTRB <= 4'hF;
    rd(TCR_OFF_TRANSLATION_CONTROL, 32'h5A3C_FFFF, AXI_OKAY);
    wr(12'h00C, 32'hFFFF_FFFF, AXI_SLVERR);
    rd(12'h00C, 32'h0000_0000, AXI_SLVERR);
  endtask
  task automatic s_long();
    logic [4:0] cf [5] = '{5'h00, 5'h00, 5'h02, 5'h04, 5'h01};
    logic [31:0] tc [5] = '{32'h0, 32'h8000_0000, 32'h0, 32'h0, 32'h0};
    logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int k = 0; k < 5; k++) begin
      set(cf[k], tc[k]);
      rd(TCR_OFF_BANK_CONFIG, 32'(cf[k]), AXI_OKAY);
      @(posedge CLK_SYS);
      #1;
      chk("long", 32'(ex[k]), 32'(LONG_DESC));
    end
  endtask
  task automatic s_walk();
    set(5'h00, 32'h8080_0000);
    expw(1'b1, 1'b0);
    wr(TCR_OFF_STATUS, 32'hFFFF_FFFF, AXI_OKAY);
    rd(TCR_OFF_STATUS, 32'h0000_00E9, AXI_OKAY);
    expw(1'b0, 1'b1);
    set(5'h00, 32'h8000_0080);
    expw(1'b0, 1'b0);
    expw(1'b1, 1'b1);
    set(5'h04, 32'h8080_0080);
    expw(1'b1, 1'b1);
    expw(1'b0, 1'b1);
    set(5'h00, 32'h0000_0020);
    expw(1'b1, 1'b0);
    expw(1'b0, 1'b1);
  endtask
  task automatic s_attr();
    logic [1:0] a, b, c, d;
    logic [31:0] t;
    for (int k = 0; k < 4; k++) begin
      a = 2'(k);
      b = a + 2'h1;
      c = a + 2'h2;
      d = a + 2'h3;
      t = {1'b1, a[0], a, b, c, 1'b0, a[1], 7'h0,
           !a[0], d, c, b, 8'h0};
      set(5'h10, t);
      @(posedge CLK_SYS);
      #1;
      chk("asid source", 32'(a[1]), 32'(ASID_FROM_UPPER));
      miss(1'b1);
      chk("upper ns", 32'(a[0]), 32'(MISS_NS));
      chk("upper sh", 32'(a), 32'(MISS_SH));
      chk("upper outer", 32'(b), 32'(MISS_OUTER));
      chk("upper inner", 32'(c), 32'(MISS_INNER));
      miss(1'b0);
      chk("lower ns", 32'(!a[0]), 32'(MISS_NS));
      chk("lower sh", 32'(d), 32'(MISS_SH));
      chk("lower outer", 32'(c), 32'(MISS_OUTER));
      chk("lower inner", 32'(b), 32'(MISS_INNER));
    end
    set(5'h00, 32'h8000_0000);
    miss(1'b1);
    chk("ns outside secure", 32'h1, 32'(MISS_NS));
  endtask
  task automatic s_region();
    set(5'h00, 32'h8007_0000);
    miss(1'b1);
    chk("upper log2", 32'h19, 32'(MISS_REGION_LOG2));
    miss(1'b0);
    chk("lower log2", 32'h20, 32'(MISS_REGION_LOG2));
    set(5'h01, 32'h003F_0010);
    miss(1'b1);
    chk("upper log2", 32'h01, 32'(MISS_REGION_LOG2));
    miss(1'b0);
    chk("lower log2", 32'h30, 32'(MISS_REGION_LOG2));
  endtask
  task automatic s_gran();
    logic [1:0] eu [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    logic [1:0] el [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    logic [31:0] t;
    for (int k = 0; k < 4; k++) begin
      t = {2'(k), 14'h0, 2'(k), 14'h0};
      set(5'h01, t);
      rd(TCR_OFF_TRANSLATION_CONTROL, t, AXI_OKAY);
      miss(1'b1);
      chk("up gran", 32'(eu[k]), 32'(MISS_GRANULE));
      miss(1'b0);
      chk("lo gran", 32'(el[k]), 32'(MISS_GRANULE));
    end
    set(5'h03, 32'hC000_4000);
    miss(1'b1);
    chk("stage2 granule", 32'h2, 32'(MISS_GRANULE));
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    s_regs();
    s_long();
    s_walk();
    s_attr();
    s_region();
    s_gran();
    stop_test();
  end
endmodule
bind tcr_translation_control tcr_checker chk_i (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY), .MISS_REQ(MISS_REQ),
  .MISS_DONE(MISS_DONE), .MISS_WALK(MISS_WALK), .MISS_FAULT(MISS_FAULT),
  .MISS_NS(MISS_NS), .MISS_SH(MISS_SH), .MISS_OUTER(MISS_OUTER),
  .MISS_INNER(MISS_INNER), .MISS_GRANULE(MISS_GRANULE),
  .MISS_REGION_LOG2(MISS_REGION_LOG2));
`default_nettype wire
